// >>> common/smps_cfg.svh
// Constants of the supply supervisor and sampler.
// Operation
// (RULE1) Each loop pass samples, decides, adjusts outputs, then waits for the tick.
// (RULE2) Loop tick is an 8-bit counter after a 4:1 prescale of the 1 MHz rate.
// (RULE3) Reference period counter counts to 3F then wraps, no pre or post scaling.
// (RULE4) Six-bit period plus two-bit sub-count make an 8-bit period near 1950 Hz.
// (RULE5) Duty is held split: two low bits with mode control, six high bits apart.
// (RULE6) Reference PWM is a single output, auto shutdown and dead-band disabled.
// (RULE7) Converter results are right-justified ten bits in low and high bytes.
// (RULE8) Converter uses supply reference, starts on input-voltage channel, set clock rate.
// (RULE9) Initialisation launches the first input-voltage conversion before sampling.
// (RULE10) Each sampler pass stores the result, picks next channel, starts conversion.
// (RULE11) Sampler index advances on each pass through every monitored input.
// (RULE12) Writing the index or skip mask reorders sampling or skips inputs.
// (RULE13) Index selects result slot, next channel value and per-channel alarm limit.
// (RULE14) Voltage-select and shutdown pins are sampled on every sampler pass.
// (RULE15) Initialisation clears results and presets the sampler index.
// (RULE16) Analog pins have their digital input buffers switched off.
// (RULE17) Only second op amp and second comparator are enabled.
// (RULE18) Analog PWM drives phase A only, ended by comparator two, offset 0, 500 kHz.
// (RULE19) Phase offset is counted from the sync pulse of the phase generator.
// (RULE20) Decision logic has a shut-down state and an active output state.
// (RULE21) Voltage-select pins form a two-bit preset number, pin zero least significant.
// (RULE22) A low shutdown input disables the supply output.
// (RULE23) Output-ok is high only with correct output, low on faults or while ramping.
// (RULE24) Loop stalls until the tick wrap flag is set, then clears it.
`ifndef SMPS_CFG_SVH
`define SMPS_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 100000000
`define INSTR_HZ 1000000
`define INSTR_CYC (`CLK_HZ / `INSTR_HZ)
`define TICK_PRESCALE 2'h3
`define TICK_TOP 8'hFF
`define REF_BASE_HZ 500000
`define REF_STEP_CYC (`CLK_HZ / `REF_BASE_HZ)
`define REF_PERIOD_TOP 6'h3F
`define REF_SUB_TOP 2'h3
`define PHASE_HZ 500000
`define PHASE_CYC (`CLK_HZ / `PHASE_HZ)
`define PHASE_OFFSET 8'h00
`define PHASE_MAX_ON (`PHASE_CYC / 2)

// ----------------------------------------------------------------
// Static analog configuration
// ----------------------------------------------------------------
`define ANALOG_PINS 8'h0F
`define OPAMP_EN 2'h2
`define COMP_EN 2'h2
`define ADC_CLOCK_SEL 3'h5
`define ADC_REF_SUPPLY 1'h0

// ----------------------------------------------------------------
// Channels
// ----------------------------------------------------------------
`define CH_TEMP 2'h0
`define CH_VOUT 2'h1
`define CH_CURRENT 2'h2
`define CH_VIN 2'h3

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INDEX 8'h08
`define REG_LOCKOUT 8'h0C
`define REG_PRESET 4'h1
`define REG_RESULT 4'h2
`define REG_LIMIT 4'h3
`define LOCKOUT_RST 10'h000
`define LIMIT_RST 10'h3FF
`define PRESET_RST 8'h00

`endif

// >>> common/smps_pkg.sv
// Types of the supply supervisor and sampler.
package smps_pkg;

  typedef enum logic [2:0] {
    L_INIT,
    L_SAMPLE,
    L_DECIDE,
    L_OUTPUT,
    L_WAIT
  } loop_t;

  typedef enum logic [1:0] {
    D_IDLE_OFF_STATE,
    D_RAMP,
    D_ACTIVE
  } dec_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic [7:0] result_low_byte;
    logic [1:0] result_high_byte;
    logic done;
  } adc_in_t;

  typedef struct packed {
    logic [1:0] channel;
    logic start;
    logic [2:0] clock_sel;
    logic ref_sel;
  } adc_out_t;

  typedef struct packed {
    loop_t loop;
    dec_t dec;
    logic [1:0] idx;
    logic start;
    logic conv_done;
    logic [3:0][9:0] result;
    logic [3:0][9:0] limit;
    logic [3:0] alarm;
    logic [3:0][7:0] preset;
    logic [9:0] lockout;
    logic [3:0] skip;
    logic [1:0] output_voltage_select;
    logic sd_n;
    logic [5:0] duty_high_bits;
    logic [1:0] pwm_mode_low;
    logic drive;
    logic ok;
    logic [6:0] instr_cnt;
    logic [1:0] pre_cnt;
    logic [7:0] tmr;
    logic tick_flag;
    logic [7:0] ref_div;
    logic [1:0] ref_sub;
    logic [5:0] ref_per;
    logic ref_out;
    logic [7:0] ph_cnt;
    logic ph_out;
    logic sync;
    logic ack;
    logic [31:0] rdata;
  } state_t;

endpackage : smps_pkg

// >>> verilog/smps_supervisor_sampler.sv
// Supply supervisor: loop sequencer, input sampler and PWM generators.
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "smps_cfg.svh"

module smps_supervisor_sampler #(
  parameter int INSTR_CYCLES = `INSTR_CYC
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire smps_pkg::avs_req_t i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire smps_pkg::adc_in_t i_adc,
  output smps_pkg::adc_out_t o_adc,
  input wire logic [1:0] i_output_voltage_select,
  input wire logic i_idle_off_state_n,
  input wire logic i_comp2_trip,
  output logic o_ref_pwm,
  output logic o_phase_a_output,
  output logic o_sync,
  output logic o_drive_enable,
  output logic o_output_ok_flag,
  output logic [7:0] o_analog_pin_select,
  output logic [1:0] o_opamp_enable,
  output logic [1:0] o_comp_enable
);
  import smps_pkg::*;

  state_t s_reg;
  state_t s_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Next channel after cur that the skip mask does not exclude.
  function automatic logic [1:0] next_index(input logic [1:0] cur,
                                            input logic [3:0] skip);
    logic [1:0] n;
    logic found;
    n = cur;
    found = 1'b0;
    for (int k = 1; k <= 4; k++)
    begin
      if (!found && !skip[2'(cur + 2'(k))])
      begin
        n = 2'(cur + 2'(k));
        found = 1'b1;
      end
    end
    return n;
  endfunction : next_index

  function automatic logic [7:0] duty_of(input state_t s);
    return {s.duty_high_bits, s.pwm_mode_low};
  endfunction : duty_of

  logic [7:0] duty;
  logic [7:0] target;
  logic [7:0] ref_count;
  logic vin_ok;
  logic [9:0] sample;
  logic bus_req;
  logic bus_go;
  logic [3:0] hi_nib;
  logic [1:0] slot;

  always_comb
  begin
    duty = duty_of(s_reg);
    target = s_reg.preset[s_reg.output_voltage_select]; // [RULE21]
    ref_count = {s_reg.ref_per, s_reg.ref_sub}; // [RULE4]
    vin_ok = s_reg.result[`CH_VIN] > s_reg.lockout;
    sample = {i_adc.result_high_byte, i_adc.result_low_byte}; // [RULE7]
    bus_req = i_avs.read | i_avs.write;
    bus_go = bus_req & s_reg.ack;
    hi_nib = i_avs.address[7:4];
    slot = i_avs.address[3:2];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.sync = 1'b0;

    // Converter completion is held until the next start; a done in the
    // start cycle itself still wins.
    if (s_reg.start)
      s_next.conv_done = 1'b0;
    if (i_adc.done)
      s_next.conv_done = 1'b1;

    // Loop tick: instruction rate, 4:1 prescale, 8-bit wrap.
    if (s_reg.instr_cnt == 7'(INSTR_CYCLES - 1)) // [RULE2]
    begin
      s_next.instr_cnt = 7'h00;
      if (s_reg.pre_cnt == `TICK_PRESCALE)
      begin
        s_next.pre_cnt = 2'h0;
        s_next.tmr = 8'(s_reg.tmr + 8'h01);
        if (s_reg.tmr == `TICK_TOP)
          s_next.tick_flag = 1'b1;
      end
      else
        s_next.pre_cnt = 2'(s_reg.pre_cnt + 2'h1);
    end
    else
      s_next.instr_cnt = 7'(s_reg.instr_cnt + 7'h01);

    // Reference PWM time base: single output, no scaling, no shutdown
    // or dead-band logic in the path.
    if (s_reg.ref_div == 8'(`REF_STEP_CYC - 1)) // [RULE6]
    begin
      s_next.ref_div = 8'h00;
      s_next.ref_sub = 2'(s_reg.ref_sub + 2'h1);
      if (s_reg.ref_sub == `REF_SUB_TOP)
      begin
        if (s_reg.ref_per == `REF_PERIOD_TOP) // [RULE3]
          s_next.ref_per = 6'h00;
        else
          s_next.ref_per = 6'(s_reg.ref_per + 6'h01);
      end
    end
    else
      s_next.ref_div = 8'(s_reg.ref_div + 8'h01);
    s_next.ref_out = ref_count < duty; // [RULE4]

    // Analog phase A: starts at the offset after sync, ends on comparator
    // two or at the maximum on-time.
    if (s_reg.ph_cnt == 8'(`PHASE_CYC - 1)) // [RULE18]
    begin
      s_next.ph_cnt = 8'h00;
      s_next.sync = 1'b1;
    end
    else
      s_next.ph_cnt = 8'(s_reg.ph_cnt + 8'h01);
    if (!s_reg.drive || i_comp2_trip ||
        s_reg.ph_cnt >= 8'(`PHASE_OFFSET + `PHASE_MAX_ON))
      s_next.ph_out = 1'b0; // [RULE18]
    else if (s_reg.ph_cnt == `PHASE_OFFSET) // [RULE19]
      s_next.ph_out = 1'b1;

    // Main loop.
    case (s_reg.loop)
      L_INIT:
      begin
        s_next.result = '0; // [RULE15]
        s_next.idx = `CH_VIN; // [RULE15] [RULE8]
        s_next.start = 1'b1; // [RULE9]
        s_next.loop = L_SAMPLE;
      end
      L_SAMPLE:
      begin
        if (s_reg.conv_done && !s_reg.start)
        begin
          s_next.result[s_reg.idx] = sample; // [RULE10] [RULE13]
          s_next.alarm[s_reg.idx] = sample > s_reg.limit[s_reg.idx]; // [RULE13]
          s_next.output_voltage_select = i_output_voltage_select; // [RULE14]
          s_next.sd_n = i_idle_off_state_n; // [RULE14]
          s_next.idx = next_index(s_reg.idx, s_reg.skip); // [RULE11]
          s_next.start = 1'b1; // [RULE10]
          s_next.loop = L_DECIDE; // [RULE1]
        end
      end
      L_DECIDE:
      begin
        case (s_reg.dec)
          D_IDLE_OFF_STATE:
          begin
            if (s_reg.sd_n && vin_ok)
              s_next.dec = D_RAMP;
          end
          D_RAMP:
          begin
            if (duty == target)
              s_next.dec = D_ACTIVE;
          end
          D_ACTIVE:
          begin
            if (duty != target)
              s_next.dec = D_RAMP;
          end
          default:
            s_next.dec = D_IDLE_OFF_STATE;
        endcase
        if (!s_reg.sd_n || !vin_ok) // [RULE22]
          s_next.dec = D_IDLE_OFF_STATE;
        s_next.loop = L_OUTPUT; // [RULE1]
      end
      L_OUTPUT:
      begin
        s_next.drive = s_reg.dec != D_IDLE_OFF_STATE; // [RULE20] [RULE22]
        s_next.ok = s_reg.dec == D_ACTIVE; // [RULE23]
        if (s_reg.dec == D_IDLE_OFF_STATE)
          {s_next.duty_high_bits, s_next.pwm_mode_low} = 8'h00;
        else if (s_reg.dec == D_RAMP && duty < target)
          {s_next.duty_high_bits, s_next.pwm_mode_low} =
            8'(duty + 8'h01); // [RULE5]
        else if (s_reg.dec == D_RAMP && duty > target)
          {s_next.duty_high_bits, s_next.pwm_mode_low} =
            8'(duty - 8'h01); // [RULE5]
        s_next.loop = L_WAIT; // [RULE1]
      end
      L_WAIT:
      begin
        if (s_reg.tick_flag) // [RULE24]
        begin
          s_next.tick_flag = 1'b0; // [RULE24]
          s_next.loop = L_SAMPLE;
        end
      end
      default:
        s_next.loop = L_INIT;
    endcase

    // A wrap in the clearing cycle is kept.
    if (s_reg.instr_cnt == 7'(INSTR_CYCLES - 1) &&
        s_reg.pre_cnt == `TICK_PRESCALE && s_reg.tmr == `TICK_TOP)
      s_next.tick_flag = 1'b1;

    // Register bus: one wait cycle, then the access completes.
    s_next.ack = bus_req & ~s_reg.ack;
    if (bus_req && !s_reg.ack)
    begin
      s_next.rdata = 32'h0000_0000;
      case (hi_nib)
        4'h0:
        begin
          case (i_avs.address)
            `REG_CTRL:
              s_next.rdata = {28'h000_0000, s_reg.skip};
            `REG_STATUS:
              s_next.rdata = {11'h000, s_reg.alarm, duty, 1'b0,
                              s_reg.ok, s_reg.sd_n, s_reg.output_voltage_select,
                              s_reg.idx, s_reg.dec};
            `REG_INDEX:
              s_next.rdata = {30'h0000_0000, s_reg.idx};
            `REG_LOCKOUT:
              s_next.rdata = {22'h00_0000, s_reg.lockout};
            default:
              s_next.rdata = 32'h0000_0000;
          endcase
        end
        `REG_PRESET:
          s_next.rdata = {24'h00_0000, s_reg.preset[slot]};
        `REG_RESULT:
          s_next.rdata = {22'h00_0000, s_reg.result[slot]};
        `REG_LIMIT:
          s_next.rdata = {22'h00_0000, s_reg.limit[slot]};
        default:
          s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (bus_go && i_avs.write)
    begin
      case (hi_nib)
        4'h0:
        begin
          case (i_avs.address)
            `REG_CTRL:
              s_next.skip = i_avs.writedata[3:0]; // [RULE12]
            `REG_INDEX:
              s_next.idx = i_avs.writedata[1:0]; // [RULE12]
            `REG_LOCKOUT:
              s_next.lockout = i_avs.writedata[9:0];
            default:
              s_next.lockout = s_reg.lockout;
          endcase
        end
        `REG_PRESET:
          s_next.preset[slot] = i_avs.writedata[7:0];
        `REG_LIMIT:
          s_next.limit[slot] = i_avs.writedata[9:0];
        default:
          s_next.lockout = s_reg.lockout;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_reg <= '0;
      s_reg.loop <= L_INIT;
      s_reg.dec <= D_IDLE_OFF_STATE; // [RULE20]
      s_reg.idx <= `CH_VIN;
      s_reg.lockout <= `LOCKOUT_RST;
      s_reg.limit <= {4{`LIMIT_RST}};
      s_reg.preset <= {4{`PRESET_RST}};
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_avs_waitrequest = bus_req & ~s_reg.ack;
  assign o_avs_readdata = s_reg.rdata;
  assign o_adc.channel = s_reg.idx; // [RULE13]
  assign o_adc.start = s_reg.start;
  assign o_adc.clock_sel = `ADC_CLOCK_SEL; // [RULE8]
  assign o_adc.ref_sel = `ADC_REF_SUPPLY; // [RULE8]
  assign o_ref_pwm = s_reg.ref_out;
  assign o_phase_a_output = s_reg.ph_out;
  assign o_sync = s_reg.sync;
  assign o_drive_enable = s_reg.drive;
  assign o_output_ok_flag = s_reg.ok;
  assign o_analog_pin_select = `ANALOG_PINS; // [RULE16]
  assign o_opamp_enable = `OPAMP_EN; // [RULE17]
  assign o_comp_enable = `COMP_EN; // [RULE17]

endmodule : smps_supervisor_sampler

// >>> tb/smps_adc_model.sv
// Converter model on the far side of the sampler.
`timescale 1ns/1ps
module smps_adc_model (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire smps_pkg::adc_out_t i_adc,
  input wire logic [3:0][9:0] i_value,
  input wire logic [7:0] i_delay,
  output smps_pkg::adc_in_t o_adc
);
  import smps_pkg::*;
  logic [1:0] chan;
  int cnt;
  // Result lines toggle while a conversion runs, then hold the result.
  always @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt <= 0;
      chan <= 2'h0;
      o_adc <= '0;
    end
    else if (i_adc.start)
    begin
      chan <= i_adc.channel;
      cnt <= i_delay + 1;
      o_adc.done <= 1'b0;
    end
    else if (cnt == 1)
    begin
      o_adc <= {i_value[chan][7:0], i_value[chan][9:8], 1'b1};
      cnt <= 0;
    end
    else
    begin
      o_adc.done <= 1'b0;
      if (cnt > 1)
      begin
        cnt <= cnt - 1;
        o_adc.result_low_byte <= ~o_adc.result_low_byte;
        o_adc.result_high_byte <= ~o_adc.result_high_byte;
      end
    end
  end
endmodule : smps_adc_model

// >>> tb/smps_checker_properties.sv
// Concurrent checks on the supervisor's ports.
`timescale 1ns/1ps
module smps_checker #(
  parameter int INSTR_CYCLES = 1
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire smps_pkg::avs_req_t i_avs,
  input wire logic o_avs_waitrequest,
  input wire smps_pkg::adc_out_t o_adc,
  input wire logic i_comp2_trip,
  input wire logic o_ref_pwm,
  input wire logic o_phase_a_output,
  input wire logic o_sync,
  input wire logic o_drive_enable,
  input wire logic o_output_ok_flag,
  input wire logic [7:0] o_analog_pin_select,
  input wire logic [1:0] o_opamp_enable,
  input wire logic [1:0] o_comp_enable
);
  import smps_pkg::*;
  logic [1:0] rel_reg;
  logic [7:0] high_reg;
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rel_reg <= 2'h0;
      high_reg <= 8'h00;
    end
    else
    begin
      rel_reg <= (rel_reg == 2'h3) ? rel_reg : rel_reg + 2'h1;
      high_reg <= o_phase_a_output ? high_reg + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  sequence s_req; $rose(i_avs.read | i_avs.write); endsequence
  sequence s_ans; o_avs_waitrequest ##1 !o_avs_waitrequest; endsequence
  property p_wait; s_req |-> s_ans; endproperty
  property p_cfg; o_analog_pin_select == 8'h0F && o_opamp_enable == 2'h2
    && o_comp_enable == 2'h2 && o_adc.ref_sel == 1'h0; endproperty
  property p_first; rel_reg == 2'h1 |->
    ##[0:2] (o_adc.start && o_adc.channel == 2'h3); endproperty
  property p_start; o_adc.start |=> !o_adc.start [*8]; endproperty
  property p_chan; $changed(o_adc.channel) |-> o_adc.start; endproperty
  property p_sync; o_sync |=> !o_sync ##199 o_sync; endproperty
  property p_trip; i_comp2_trip && o_phase_a_output
    |=> !o_phase_a_output; endproperty
  property p_width; high_reg < 8'd101; endproperty
  property p_drive; $rose(o_phase_a_output) |-> $past(o_drive_enable);
  endproperty
  property p_ok; o_output_ok_flag |-> o_drive_enable; endproperty
  property p_refoff; !o_drive_enable && !$past(o_drive_enable)
    |-> !o_ref_pwm; endproperty
  a_wait: assert property (p_wait)
    else $error("bus answer not after one wait cycle");
  a_cfg: assert property (p_cfg)
    else $error("static analog setup wrong");
  a_first: assert property (p_first)
    else $error("no input-voltage conversion after reset");
  a_start: assert property (p_start)
    else $error("conversion starts too close");
  a_chan: assert property (p_chan)
    else $error("channel changed without a start");
  a_sync: assert property (p_sync)
    else $error("sync spacing wrong");
  a_trip: assert property (p_trip)
    else $error("phase pulse not ended by comparator");
  a_width: assert property (p_width)
    else $error("phase pulse too wide");
  a_drive: assert property (p_drive)
    else $error("phase pulse without drive");
  a_ok: assert property (p_ok)
    else $error("output ok while drive off");
  a_refoff: assert property (p_refoff)
    else $error("reference pulse while shut down");
endmodule : smps_checker

bind smps_supervisor_sampler smps_checker #(
  .INSTR_CYCLES(INSTR_CYCLES)
) chk_i (
  .i_clock(i_clock),
  .i_arst_n(i_arst_n),
  .i_avs(i_avs),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_adc(o_adc),
  .i_comp2_trip(i_comp2_trip),
  .o_ref_pwm(o_ref_pwm),
  .o_phase_a_output(o_phase_a_output),
  .o_sync(o_sync),
  .o_drive_enable(o_drive_enable),
  .o_output_ok_flag(o_output_ok_flag),
  .o_analog_pin_select(o_analog_pin_select),
  .o_opamp_enable(o_opamp_enable),
  .o_comp_enable(o_comp_enable)
);

// >>> tb/test_smps_supervisor_sampler.sv
// Self-checking bench of the supply supervisor.
`timescale 1ns/1ps
`include "smps_cfg.svh"
module test_smps_supervisor_sampler;
  import smps_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  avs_req_t avs = '0;
  logic [31:0] rdata;
  logic wreq;
  adc_in_t adc_i;
  adc_out_t adc_o;
  logic [1:0] output_voltage_select = 0;
  logic sd_n = 0;
  logic trip = 0;
  logic refp, phase_a_output, sync, drv, ok;
  logic [3:0][9:0] val = '0;
  logic [7:0] dly = 8'h08;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int refk = 0;
  int refn;
  int chq[$];
  logic [31:0] q;
  always #5 clk = ~clk;
  smps_supervisor_sampler #(.INSTR_CYCLES(1)) dut (.i_clock(clk),
    .i_arst_n(rst_n), .i_avs(avs), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_adc(adc_i), .o_adc(adc_o),
    .i_output_voltage_select(output_voltage_select), .i_idle_off_state_n(sd_n),
    .i_comp2_trip(trip), .o_ref_pwm(refp), .o_phase_a_output(phase_a_output),
    .o_sync(sync), .o_drive_enable(drv), .o_output_ok_flag(ok),
    .o_analog_pin_select(), .o_opamp_enable(), .o_comp_enable());
  smps_adc_model partner (.i_clock(clk), .i_arst_n(rst_n),
    .i_adc(adc_o), .i_value(val), .i_delay(dly), .o_adc(adc_i));
  always @(posedge clk)
  begin
    cycles++;
    trip <= ($urandom_range(63) == 0);
    // Reference count steps every 200 cycles over 256 steps; duty stays
    // below 8 here, so the pulse must be low once the count is past 9.
    if (rst_n === 1'b1)
      refk++;
    refn = (refk / 200) % 256;
    if (refn >= 10)
      chk(refp, 1'b0);
    if (adc_o.start === 1'b1)
      chq.push_back(int'(adc_o.channel));
    if (cycles == 80000)
    begin
      failures++;
      summarize();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs <= '{address: a, read: !wr, write: wr, writedata: d};
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    avs <= '0;
    @(posedge clk);
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task ticks(input int n);
    repeat (n * 1024) @(posedge clk);
  endtask : ticks
  function automatic logic [7:0] ra(input logic [3:0] k, input int i);
    return {k, i[1:0], 2'b00};
  endfunction : ra
  // Expected order: next channel after the last that is not skipped.
  task chk_order(input logic [3:0] skip);
    int e;
    for (int i = 1; i < chq.size(); i++)
    begin
      e = chq[i - 1];
      do e = (e + 1) % 4; while (skip[e]);
      chk(chq[i], e);
    end
    chq.delete();
  endtask : chk_order
  task done(input int n);
    $display("test %0d finished", n);
  endtask : done
  task status(input int dec, input logic o);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk(q[1:0], dec);
    chk(q[7], o);
    chk(drv, dec != 0);
    chk(ok, o);
  endtask : status
  task summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  initial
  begin
    void'($urandom(32'hda1b));
    for (int i = 0; i < 4; i++)
      val[i] = 10'($urandom_range(1023, 1));
    val[3][9] = 1'b1;
    output_voltage_select = 2'($urandom_range(3));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`REG_LOCKOUT, 32'h0);
    for (int i = 0; i < 3; i++)
      rd(ra(`REG_RESULT, i), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      rd(ra(`REG_PRESET, i), 32'h0);
      rd(ra(`REG_LIMIT, i), 32'h3FF);
    end
    bus(1'b1, ra(`REG_RESULT, 0), 32'h55);
    rd(ra(`REG_RESULT, 0), 32'h0);
    rd(8'hFC, 32'h0);
    rd(`REG_CTRL, 32'h0);
    rd(`REG_INDEX, 32'h0);
    done(1);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, ra(`REG_PRESET, i), 4 + i);
      bus(1'b1, ra(`REG_LIMIT, i), (i == 0) ? 32'h0 : 32'h3FF);
    end
    bus(1'b1, `REG_LOCKOUT, 32'h10);
    dly <= 8'h30;
    chq.delete();
    ticks(6);
    chk_order(4'h0);
    for (int i = 0; i < 4; i++)
      rd(ra(`REG_RESULT, i), val[i]);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk(q[20:17], 4'h1);
    chk(q[5:4], output_voltage_select);
    status(0, 1'b0);
    done(2);
    bus(1'b1, `REG_CTRL, 32'h2);
    ticks(1);
    chq.delete();
    ticks(6);
    chk_order(4'h2);
    bus(1'b1, `REG_CTRL, 32'h0);
    done(3);
    sd_n <= 1'b1;
    ticks(16);
    status(2, 1'b1);
    chk(q[16:9], 4 + output_voltage_select);
    chk(q[6], 1'b1);
    done(4);
    val[3] <= 10'h008;
    ticks(6);
    status(0, 1'b0);
    done(5);
    val[3][9] <= 1'b1;
    ticks(16);
    status(2, 1'b1);
    sd_n <= 1'b0;
    ticks(2);
    status(0, 1'b0);
    done(6);
    summarize();
  end
endmodule : test_smps_supervisor_sampler
